//--- rtl/dio_pkg.sv
// Shared constants and types for the digital I/O supervision block.
// Assumes a single 20 MHz module clock and a plain register port.
package dio_pkg;

  // Clock, documented times and threshold range
  localparam int          CLOCK_HZ        = 20_000_000;
  localparam int          HOLD_SHORT_MS   = 15;
  localparam int          HOLD_MID_MS     = 100;
  localparam int          HOLD_LONG_MS    = 200;
  localparam longint      SAVE_PERIOD_S   = 3600;
  localparam int          THRESHOLD_UNIT  = 1000;
  localparam logic [15:0] THRESHOLD_MIN   = 16'h0001;
  localparam logic [15:0] THRESHOLD_MAX   = 16'hFDE8;

  // Widths
  localparam int REG_ADDR_W    = 8;
  localparam int DATA_W        = 32;
  localparam int COUNT_W       = 32;
  localparam int RETAIN_ADDR_W = 8;
  localparam int THRESH_W      = 16;
  localparam int TIMER_W       = 40;

  // Register offsets (byte addresses)
  localparam logic [REG_ADDR_W-1:0] REG_CONFIG      = 8'h00;
  localparam logic [REG_ADDR_W-1:0] REG_OPEN_EN     = 8'h04;
  localparam logic [REG_ADDR_W-1:0] REG_FAULT_MODE  = 8'h08;
  localparam logic [REG_ADDR_W-1:0] REG_IDLE_MODE   = 8'h0C;
  localparam logic [REG_ADDR_W-1:0] REG_THRESHOLD   = 8'h10;
  localparam logic [REG_ADDR_W-1:0] REG_DIAG        = 8'h14;
  localparam logic [REG_ADDR_W-1:0] REG_INT_STATUS  = 8'h18;
  localparam logic [REG_ADDR_W-1:0] REG_INT_MASK    = 8'h1C;
  localparam logic [REG_ADDR_W-1:0] REG_COUNT_SEL   = 8'h20;
  localparam logic [REG_ADDR_W-1:0] REG_COUNT_VALUE = 8'h24;
  localparam logic [REG_ADDR_W-1:0] REG_INPUT_STATE = 8'h28;

  // CONFIG field positions and reset values, plus the THRESHOLD reset value
  localparam int   CFG_HOLD_LSB      = 0;
  localparam int   CFG_SHORT_EN_BIT  = 2;
  localparam int   CFG_RESTART_BIT   = 3;
  localparam int   CFG_COUNT_EN_BIT  = 4;
  localparam logic SHORT_EN_RESET    = 1'b1;
  localparam logic RESTART_RESET     = 1'b0;
  localparam logic COUNT_EN_RESET    = 1'b0;
  localparam logic [THRESH_W-1:0] THRESHOLD_RESET = 16'h0001;

  typedef enum logic [1:0] {
    HOLD_15  = 2'b00,
    HOLD_100 = 2'b01,
    HOLD_200 = 2'b10
  } hold_sel_type;

  typedef enum logic [1:0] {
    FAULT_CLEAR    = 2'b00,
    FAULT_HOLD     = 2'b01,
    FAULT_FORCE_ON = 2'b10
  } fault_mode_type;

  typedef enum logic [1:0] {
    ST_RESTORE = 2'b00,
    ST_RUN     = 2'b01,
    ST_SAVE    = 2'b10
  } phase_type;

  typedef struct packed {
    logic [REG_ADDR_W-1:0] addr;
    logic [DATA_W-1:0]     wdata;
    logic                  wr;
    logic                  rd;
  } reg_req_type;

  typedef struct packed {
    logic                     wr;
    logic                     rd;
    logic [RETAIN_ADDR_W-1:0] addr;
    logic [COUNT_W-1:0]       wdata;
  } retain_req_type;

endpackage

//--- rtl/input_stretch.sv
// Per-channel input hold: each accepted change is kept for the hold time.
// Assumes inputs already synchronous to clock and a synchronised reset.
`timescale 1ns/1ps
module input_stretch
  import dio_pkg::*;
#(
  parameter int          NCH               = 8,
  parameter logic [31:0] HOLD_SHORT_CYCLES = 32'd300000,
  parameter logic [31:0] HOLD_MID_CYCLES   = 32'd2000000,
  parameter logic [31:0] HOLD_LONG_CYCLES  = 32'd4000000
) (
  // Clock, reset, enable
  input  logic               clock,
  input  logic               rst_sync_n,
  input  logic               ce,
  // Control
  input  logic [1:0]         hold_sel,
  // Data
  input  logic [NCH-1:0]     raw_in,
  output logic [NCH-1:0]     held_in
);

  typedef struct packed {
    logic [NCH-1:0][31:0] timer;
    logic [NCH-1:0]       held;
  } stretch_state_type;

  stretch_state_type s;
  stretch_state_type next_s;
  logic [31:0]       hold_cycles;

  // Unused select code falls back to the shortest hold
  always_comb begin
    case (hold_sel)
      HOLD_100: hold_cycles = HOLD_MID_CYCLES;
      HOLD_200: hold_cycles = HOLD_LONG_CYCLES;
      default:  hold_cycles = HOLD_SHORT_CYCLES;
    endcase
  end

  for (genvar i = 0; i < NCH; i++) begin : g_chan
    assign next_s.timer[i] = (s.timer[i] != 32'h0) ? s.timer[i] - 32'h1 :
                             (raw_in[i] != s.held[i]) ? hold_cycles - 32'h1 : 32'h0;
    assign next_s.held[i]  = (s.timer[i] == 32'h0) ? raw_in[i] : s.held[i];
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign held_in = s.held;

  AST_HOLD_STEADY: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (s.timer[0] != 32'h0) |=> (s.held[0] == $past(s.held[0])))
    else $error("held input changed inside hold time");

endmodule

//--- rtl/dio_supervisor.sv
// Digital I/O unit supervision: input hold, output fault handling,
// short/open detection, ON counters with hourly retention, diagnostics.
// Assumes field inputs synchronous to clock and a retained store that
// answers a read one cycle later.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
module dio_supervisor
  import dio_pkg::*;
#(
  parameter int                 NCH                = 8,
  parameter logic               COUNT_OUTPUTS      = 1'b1,
  parameter logic [31:0]        HOLD_SHORT_CYCLES  = 32'(HOLD_SHORT_MS * (CLOCK_HZ / 1000)),
  parameter logic [31:0]        HOLD_MID_CYCLES    = 32'(HOLD_MID_MS * (CLOCK_HZ / 1000)),
  parameter logic [31:0]        HOLD_LONG_CYCLES   = 32'(HOLD_LONG_MS * (CLOCK_HZ / 1000)),
  parameter logic [TIMER_W-1:0] SAVE_PERIOD_CYCLES = TIMER_W'(SAVE_PERIOD_S * CLOCK_HZ)
) (
  // Clock, reset, enable
  input  logic                   clock,
  input  logic                   rstn,
  input  logic                   ce,
  // Register port
  input  reg_req_type            reg_req,
  output logic [DATA_W-1:0]      reg_rdata,
  // Field side
  input  logic [NCH-1:0]         field_in,
  input  logic                   load_short,
  input  logic [NCH-1:0]         load_open,
  output logic [NCH-1:0]         out_drive,
  output logic [NCH-1:0]         in_held,
  // Controller side
  input  logic [NCH-1:0]         out_cmd,
  input  logic                   comm_fault,
  input  logic                   comm_idle,
  output logic [2*NCH:0]         diag_status,
  output logic                   irq,
  // Retained counter storage
  output retain_req_type         retain_req,
  input  logic [COUNT_W-1:0]     retain_rdata
);

  localparam int ST_W      = 2 * NCH + 1;
  localparam int SHORT_BIT = 2 * NCH;

  typedef struct packed {
    phase_type                     phase;
    logic [RETAIN_ADDR_W-1:0]      idx;
    logic                          pend;
    logic [TIMER_W-1:0]            hour_timer;
    logic [NCH-1:0][COUNT_W-1:0]   count;
    logic [NCH-1:0]                prev_on;
    logic [NCH-1:0]                drive;
    logic                          short_err;
    logic [NCH-1:0]                open_err;
    logic [NCH-1:0]                count_err;
    logic [1:0]                    hold_sel;
    logic                          short_en;
    logic                          restart_manual;
    logic                          count_en;
    logic [NCH-1:0]                open_en;
    logic [NCH-1:0][1:0]           fault_mode;
    logic [NCH-1:0][1:0]           idle_mode;
    logic [THRESH_W-1:0]           threshold;
    logic [ST_W-1:0]               mask;
    logic [ST_W-1:0]               status;
    logic [ST_W-1:0]               diag_prev;
    logic [RETAIN_ADDR_W-1:0]      count_sel;
    logic [DATA_W-1:0]             rdata;
    retain_req_type                retain_req;
  } top_state_type;

  top_state_type               s;
  top_state_type               next_s;
  logic [1:0]                  rst_pipe;
  logic                        rst_sync_n;
  logic [NCH-1:0]              chan_on;
  logic [NCH-1:0]              rise;
  logic [NCH-1:0]              next_drive;
  logic [NCH-1:0]              next_open;
  logic [NCH-1:0]              next_count_err;
  logic [NCH-1:0][COUNT_W-1:0] counted;
  logic [COUNT_W-1:0]          limit;
  logic [ST_W-1:0]             diag;
  logic [ST_W-1:0]             events;
  logic [ST_W-1:0]             status_clear;
  logic [THRESH_W-1:0]         thr_wr;
  logic                        cfg_write;
  logic                        thr_write;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and input hold

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_sync_n = rst_pipe[1];

  input_stretch #(
    .NCH               (NCH),
    .HOLD_SHORT_CYCLES (HOLD_SHORT_CYCLES),
    .HOLD_MID_CYCLES   (HOLD_MID_CYCLES),
    .HOLD_LONG_CYCLES  (HOLD_LONG_CYCLES)
  ) u_stretch (
    .clock      (clock),
    .rst_sync_n (rst_sync_n),
    .ce         (ce),
    .hold_sel   (s.hold_sel),
    .raw_in     (field_in),
    .held_in    (in_held)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel output, detection and counting

  // Limit stays below 2^26, so the product never wraps
  assign limit = COUNT_W'(s.threshold) * COUNT_W'(THRESHOLD_UNIT);

  for (genvar i = 0; i < NCH; i++) begin : g_chan
    // Idle wins over fault; the stored idle mode is deliberately ignored
    assign next_drive[i] = comm_idle  ? 1'b0 :
                           !comm_fault ? out_cmd[i] :
                           (s.fault_mode[i] == FAULT_HOLD)     ? s.drive[i] :
                           (s.fault_mode[i] == FAULT_FORCE_ON);
    assign next_open[i]  = s.open_en[i] & load_open[i];
    assign chan_on[i]    = COUNT_OUTPUTS ? s.drive[i] : in_held[i];
    assign rise[i]       = chan_on[i] & ~s.prev_on[i];
    // Counting is suspended until the saved values are back
    assign counted[i]    = (rise[i] && s.phase != ST_RESTORE && s.count[i] != '1) ?
                           s.count[i] + COUNT_W'(1) : s.count[i];
    assign next_count_err[i] = s.count_en & (s.count[i] > limit);
  end

  assign diag   = {s.short_err, s.count_err, s.open_err};
  assign events = diag & ~s.diag_prev;

  // Out-of-range threshold writes are clamped into 1..65000
  assign thr_wr = (reg_req.wdata[THRESH_W-1:0] < THRESHOLD_MIN) ? THRESHOLD_MIN :
                  (reg_req.wdata[THRESH_W-1:0] > THRESHOLD_MAX) ? THRESHOLD_MAX :
                  reg_req.wdata[THRESH_W-1:0];

  assign cfg_write    = reg_req.wr && (reg_req.addr == REG_CONFIG);
  assign thr_write    = reg_req.wr && (reg_req.addr == REG_THRESHOLD);
  assign status_clear = (reg_req.rd && reg_req.addr == REG_INT_STATUS) ? s.status : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_s            = s;
    next_s.retain_req = '0;
    next_s.rdata      = '0;
    next_s.drive      = next_drive;
    next_s.open_err   = next_open;
    next_s.count_err  = next_count_err;
    next_s.prev_on    = chan_on;
    next_s.count      = counted;
    next_s.diag_prev  = diag;
    // A new event outweighs a clearing read in the same cycle
    next_s.status     = (s.status & ~status_clear) | events;

    if (!s.short_en) begin
      next_s.short_err = 1'b0;
    end else if (load_short) begin
      next_s.short_err = 1'b1;
    end else if (!s.restart_manual) begin
      next_s.short_err = 1'b0;
    end

    if (reg_req.wr) begin
      case (reg_req.addr)
        REG_CONFIG: begin
          next_s.hold_sel       = reg_req.wdata[CFG_HOLD_LSB +: 2];
          next_s.short_en       = reg_req.wdata[CFG_SHORT_EN_BIT];
          next_s.restart_manual = reg_req.wdata[CFG_RESTART_BIT];
          next_s.count_en       = reg_req.wdata[CFG_COUNT_EN_BIT];
        end
        REG_OPEN_EN:    next_s.open_en    = reg_req.wdata[NCH-1:0];
        REG_FAULT_MODE: next_s.fault_mode = reg_req.wdata[2*NCH-1:0];
        REG_IDLE_MODE:  next_s.idle_mode  = reg_req.wdata[2*NCH-1:0];
        REG_THRESHOLD:  next_s.threshold  = thr_wr;
        REG_INT_MASK:   next_s.mask       = reg_req.wdata[ST_W-1:0];
        REG_COUNT_SEL:  next_s.count_sel  = reg_req.wdata[RETAIN_ADDR_W-1:0];
        default: begin
        end
      endcase
    end

    if (reg_req.rd) begin
      case (reg_req.addr)
        REG_CONFIG:      next_s.rdata = DATA_W'({s.count_en, s.restart_manual,
                                                 s.short_en, s.hold_sel});
        REG_OPEN_EN:     next_s.rdata = DATA_W'(s.open_en);
        REG_FAULT_MODE:  next_s.rdata = DATA_W'(s.fault_mode);
        REG_IDLE_MODE:   next_s.rdata = DATA_W'(s.idle_mode);
        REG_THRESHOLD:   next_s.rdata = DATA_W'(s.threshold);
        REG_DIAG:        next_s.rdata = DATA_W'(diag);
        REG_INT_STATUS:  next_s.rdata = DATA_W'(s.status);
        REG_INT_MASK:    next_s.rdata = DATA_W'(s.mask);
        REG_COUNT_SEL:   next_s.rdata = DATA_W'(s.count_sel);
        REG_COUNT_VALUE: next_s.rdata = (s.count_sel < RETAIN_ADDR_W'(NCH)) ?
                                        s.count[s.count_sel] : '0;
        REG_INPUT_STATE: next_s.rdata = DATA_W'(in_held);
        default:         next_s.rdata = '0;
      endcase
    end

    // Hour timer runs from the end of restore, saves included
    if (s.phase != ST_RESTORE) begin
      if (s.hour_timer == SAVE_PERIOD_CYCLES - TIMER_W'(1)) begin
        next_s.hour_timer = '0;
      end else begin
        next_s.hour_timer = s.hour_timer + TIMER_W'(1);
      end
    end

    case (s.phase)
      ST_RESTORE: begin
        if (!s.pend) begin
          next_s.retain_req.rd   = 1'b1;
          next_s.retain_req.addr = s.idx;
          next_s.pend            = 1'b1;
        end else if (!s.retain_req.rd) begin
          // The store answers in the cycle after the strobe, not during it
          next_s.count[s.idx] = retain_rdata;
          next_s.pend         = 1'b0;
          if (s.idx == RETAIN_ADDR_W'(NCH - 1)) begin
            next_s.idx   = '0;
            next_s.phase = ST_RUN;
          end else begin
            next_s.idx = s.idx + RETAIN_ADDR_W'(1);
          end
        end
      end
      ST_RUN: begin
        if (s.hour_timer == SAVE_PERIOD_CYCLES - TIMER_W'(1)) begin
          next_s.phase = ST_SAVE;
        end
      end
      ST_SAVE: begin
        // One word per cycle; an ON edge on a channel already written or being written lands in the next save
        next_s.retain_req.wr    = 1'b1;
        next_s.retain_req.addr  = s.idx;
        next_s.retain_req.wdata = s.count[s.idx];
        if (s.idx == RETAIN_ADDR_W'(NCH - 1)) begin
          next_s.idx   = '0;
          next_s.phase = ST_RUN;
        end else begin
          next_s.idx = s.idx + RETAIN_ADDR_W'(1);
        end
      end
      default: begin
        next_s.phase = ST_RESTORE;
        next_s.idx   = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; manual short latch clears here at power-up, or when a CONFIG write clears short_en or restart_manual

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s                <= '0;
      s.phase          <= ST_RESTORE;
      s.short_en       <= SHORT_EN_RESET;
      s.restart_manual <= RESTART_RESET;
      s.count_en       <= COUNT_EN_RESET;
      s.threshold      <= THRESHOLD_RESET;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign out_drive   = s.drive;
  assign diag_status = diag;
  assign irq         = |(s.status & s.mask);
  assign reg_rdata   = s.rdata;
  assign retain_req  = s.retain_req;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_n);

  AST_IDLE_OFF: assert property (
    ce && comm_idle |=> out_drive == '0)
    else $error("output driven during communication idle");

  AST_FAULT_FORCE: assert property (
    ce && !comm_idle && comm_fault && s.fault_mode[0] == FAULT_FORCE_ON |=> out_drive[0])
    else $error("forced-on channel not driven on fault");

  AST_FAULT_HOLD: assert property (
    ce && !comm_idle && comm_fault && s.fault_mode[0] == FAULT_HOLD
    |=> out_drive[0] == $past(out_drive[0]))
    else $error("held channel changed on fault");

  AST_SHORT_OFF: assert property (
    ce && !s.short_en |=> !diag_status[SHORT_BIT])
    else $error("short error raised while detection disabled");

  AST_SHORT_AUTO: assert property (
    ce && !s.restart_manual && !load_short |=> !s.short_err)
    else $error("short error not cleared in auto restart");

  AST_SHORT_LATCH: assert property (
    ce && s.short_en && s.restart_manual && s.short_err && !cfg_write |=> s.short_err)
    else $error("latched short error released");

  AST_OPEN_ERR: assert property (
    ce && s.open_en[0] && load_open[0] |=> diag_status[0])
    else $error("open load not reported");

  AST_COUNT_ERR: assert property (
    ce && s.count_en && !thr_write && s.count[0] > COUNT_W'(s.threshold) * COUNT_W'(1000)
    |=> s.count_err[0])
    else $error("count above threshold not reported");

  AST_COUNT_STEP: assert property (
    ce && s.phase != ST_RESTORE && rise[0] && s.count[0] != '1
    |=> s.count[0] == $past(s.count[0]) + COUNT_W'(1))
    else $error("ON edge not counted");

  AST_SAVE_START: assert property (
    ce && s.phase == ST_RUN && s.hour_timer == SAVE_PERIOD_CYCLES - TIMER_W'(1)
    |=> s.phase == ST_SAVE ##1 (!$past(ce) || retain_req.wr))
    else $error("hourly save not started");

  AST_RESTORE_LOAD: assert property (
    ce && s.phase == ST_RESTORE && s.pend && !s.retain_req.rd && s.idx == '0
    |=> s.count[0] == $past(retain_rdata))
    else $error("saved count not restored");

  AST_STATUS_SET: assert property (
    ce && diag[SHORT_BIT] && !s.diag_prev[SHORT_BIT] |=> s.status[SHORT_BIT])
    else $error("short event not latched in status");

  COV_RESTORE_DONE: cover property (s.phase == ST_RESTORE ##1 s.phase == ST_RUN);
  COV_SAVE:         cover property (s.phase == ST_SAVE && retain_req.wr);
  COV_FORCE_ON:     cover property (comm_fault && !comm_idle && out_drive[0] && !out_cmd[0]);
  COV_COUNT_ERR:    cover property (s.count_err[0] && irq);

endmodule

//--- tb/retain_store.sv
// Retained counter store on the far side of the retain port.
// Assumes dio_pkg and requests that change just after a rising edge.
`timescale 1ns/1ps
module retain_store
  import dio_pkg::*;
(
  // Clock
  input  logic               clock,
  // Retain port
  input  retain_req_type     retain_req,
  output logic [COUNT_W-1:0] retain_rdata
);
  logic [COUNT_W-1:0] mem [256];
  logic [COUNT_W-1:0] last = 32'h0;

  // Channel 0 starts at the default limit so one more ON crosses it
  initial begin
    foreach (mem[i]) mem[i] = 32'h0;
    mem[0] = 32'h3E8;
  end

  always @(posedge clock) begin
    if (retain_req.wr) begin
      mem[retain_req.addr] <= retain_req.wdata;
    end
    // Toggle outside the answer cycle so stale data never looks valid
    last <= retain_req.rd ? mem[retain_req.addr] : ~last;
  end

  assign retain_rdata = last;
endmodule

//--- tb/tb_top.sv
// Self-checking bench for dio_supervisor, one task per scenario.
// Assumes short hold and save parameters and the retain_store model.
`timescale 1ns/1ps
module tb_top;
  import dio_pkg::*;
  localparam int NCH = 8;
  logic                 clock = 1'b0;
  logic                 rstn = 1'b0;
  logic                 ce = 1'b1;
  reg_req_type          reg_req = '0;
  logic [DATA_W-1:0]    reg_rdata;
  logic [NCH-1:0]       field_in = '0;
  logic                 load_short = 1'b0;
  logic [NCH-1:0]       load_open = '0;
  logic [NCH-1:0]       out_cmd = '0;
  logic                 comm_fault = 1'b0;
  logic                 comm_idle = 1'b0;
  logic [NCH-1:0]       out_drive;
  logic [NCH-1:0]       in_held;
  logic [2*NCH:0]       diag_status;
  logic                 irq;
  retain_req_type       retain_req;
  logic [COUNT_W-1:0]   retain_rdata;
  int                   err_count = 0;
  int                   tests_run = 0;

  always #25 clock = ~clock;

  // Counting on outputs is the default source
  dio_supervisor #(.NCH(NCH), .HOLD_SHORT_CYCLES(32'h14),
    .HOLD_MID_CYCLES(32'h28), .HOLD_LONG_CYCLES(32'h3C), .SAVE_PERIOD_CYCLES(40'hC8))
  i_dio_supervisor (.clock(clock), .rstn(rstn), .ce(ce), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .field_in(field_in), .load_short(load_short),
    .load_open(load_open), .out_drive(out_drive), .in_held(in_held), .out_cmd(out_cmd),
    .comm_fault(comm_fault), .comm_idle(comm_idle), .diag_status(diag_status), .irq(irq),
    .retain_req(retain_req), .retain_rdata(retain_rdata));

  retain_store i_retain_store (.clock(clock), .retain_req(retain_req),
    .retain_rdata(retain_rdata));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_req <= {a, d, 1'b1, 1'b0};
    @(posedge clock);
    reg_req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_req <= {a, 32'h0, 1'b0, 1'b1};
    @(posedge clock);
    reg_req.rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic set_short(input logic s);
    @(posedge clock);
    load_short <= s;
    settle(3);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // First pass runs on the reset hold setting; each pass also waits out the
  // hold of the falling change, or the next pulse would be swallowed
  task automatic test_hold();
    for (int s = 0; s < 3; s++) begin
      if (s > 0) reg_write(REG_CONFIG, 32'h4 | 32'(s));
      @(posedge clock);
      field_in[0] <= 1'b1;
      @(posedge clock);
      field_in[0] <= 1'b0;
      settle(10 + 20 * s);
      chk(32'(in_held[0]), 32'h1);
      settle(20);
      chk(32'(in_held[0]), 32'h0);
      settle(20 + 20 * s);
    end
  endtask

  task automatic test_count();
    logic [31:0] v;
    reg_write(REG_COUNT_SEL, 32'h0);
    reg_read(REG_COUNT_VALUE, v);
    chk(v, 32'h3E8);
    reg_write(REG_CONFIG, 32'h14);
    settle(2);
    chk(32'(diag_status[NCH]), 32'h0);
    @(posedge clock);
    out_cmd[0] <= 1'b1;
    @(posedge clock);
    out_cmd[0] <= 1'b0;
    settle(4);
    reg_read(REG_COUNT_VALUE, v);
    chk(v, 32'h3E9);
    chk(32'(diag_status[NCH]), 32'h1);
    reg_read(REG_INT_STATUS, v);
    chk(v, 32'h100);
    reg_write(REG_THRESHOLD, 32'h0);
    reg_read(REG_THRESHOLD, v);
    chk(v, 32'h1);
    reg_write(REG_THRESHOLD, 32'hFFFF);
    reg_read(REG_THRESHOLD, v);
    chk(v, 32'hFDE8);
  endtask

  task automatic test_outputs();
    reg_write(REG_FAULT_MODE, 32'hE4);
    reg_write(REG_IDLE_MODE, 32'hAAAA);
    @(posedge clock);
    out_cmd <= 8'h03;
    settle(3);
    chk(32'(out_drive), 32'h3);
    @(posedge clock);
    out_cmd <= 8'h00;
    comm_fault <= 1'b1;
    settle(3);
    chk(32'(out_drive), 32'h6);
    @(posedge clock);
    comm_idle <= 1'b1;
    settle(3);
    chk(32'(out_drive), 32'h0);
    @(posedge clock);
    comm_idle <= 1'b0;
    comm_fault <= 1'b0;
    settle(3);
  endtask

  task automatic test_short();
    logic [31:0] v;
    set_short(1'b1);
    chk(32'(diag_status[2*NCH]), 32'h1);
    chk(32'(irq), 32'h0);
    reg_write(REG_INT_MASK, 32'h10000);
    settle(1);
    chk(32'(irq), 32'h1);
    set_short(1'b0);
    chk(32'(diag_status[2*NCH]), 32'h0);
    reg_read(REG_INT_STATUS, v);
    chk(v, 32'h10000);
    settle(1);
    chk(32'(irq), 32'h0);
    reg_write(REG_CONFIG, 32'h1C);
    set_short(1'b1);
    set_short(1'b0);
    chk(32'(diag_status[2*NCH]), 32'h1);
    reg_write(REG_CONFIG, 32'h10);
    set_short(1'b1);
    chk(32'(diag_status[2*NCH]), 32'h0);
    set_short(1'b0);
  endtask

  task automatic test_open();
    @(posedge clock);
    load_open <= 8'h08;
    settle(3);
    chk(32'(diag_status[3]), 32'h0);
    reg_write(REG_OPEN_EN, 32'h8);
    settle(2);
    chk(32'(diag_status[3]), 32'h1);
    @(posedge clock);
    load_open <= 8'h00;
  endtask

  // Low enable freezes the outputs and drops a register write
  task automatic test_freeze();
    logic [31:0] v;
    @(posedge clock);
    ce <= 1'b0;
    out_cmd[5] <= 1'b1;
    reg_write(REG_THRESHOLD, 32'h5);
    #1;
    chk(32'(out_drive[5]), 32'h0);
    @(posedge clock);
    ce <= 1'b1;
    settle(2);
    chk(32'(out_drive[5]), 32'h1);
    reg_read(REG_THRESHOLD, v);
    chk(v, 32'hFDE8);
    @(posedge clock);
    out_cmd[5] <= 1'b0;
    settle(2);
  endtask

  // Longer than one save period after the last count change
  task automatic test_save();
    settle(250);
    chk(i_retain_store.mem[0], 32'h3EA);
    chk(i_retain_store.mem[2], 32'h1);
    chk(i_retain_store.mem[5], 32'h1);
  endtask

  // Mid-run power cycle: latch released, defaults back, counts resumed
  task automatic test_power();
    logic [31:0] v;
    reg_write(REG_CONFIG, 32'hC);
    set_short(1'b1);
    set_short(1'b0);
    chk(32'(diag_status[2*NCH]), 32'h1);
    @(posedge clock);
    rstn <= 1'b0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    settle(40);
    chk(32'(diag_status[2*NCH]), 32'h0);
    reg_read(REG_CONFIG, v);
    chk(v, 32'h4);
    reg_write(REG_COUNT_SEL, 32'h0);
    reg_read(REG_COUNT_VALUE, v);
    chk(v, 32'h3EA);
  endtask

  task automatic summarize();
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    settle(30);
    test_hold();
    test_count();
    test_outputs();
    test_short();
    test_open();
    test_freeze();
    test_save();
    test_power();
    summarize();
  end

  initial begin
    repeat (5000) @(posedge clock);
    err_count++;
    summarize();
  end
endmodule
